// ==== hdl/itbt_timer.sv ====
// interval and time-base timer with divided clock output and axi4-lite slave
// assumes a free-running 32.768 kHz watch clock on watch_clk_pin
`timescale 1ns/1ps
module itbt_timer
    import itbt_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic watch_clk_pin,
    output logic divided_clock_out,
    output logic irq,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    itbt_edge_if watch_ev ();

    logic [7:0] timer_mode_select_q;
    logic [7:0] timer_count_value_q;
    logic [7:0] count_d;
    logic [SYS_PRE_W-1:0] system_prescaler_q;
    logic [WATCH_PRE_W-1:0] watch_prescaler_q;
    logic overflow_request_flag_q;
    logic overflow_irq_enable_q;
    logic clkout_enable_q;
    itbt_power_type power_q;
    logic clkout_q;
    logic irq_q;

    logic aw_have_q;
    logic w_have_q;
    logic [15:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [7:0] rbyte_q;
    logic [1:0] rresp_q;

    // watch pin passes two flip-flops before any use
    itbt_sync_edge u_watch_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in(watch_clk_pin),
        .ev(watch_ev)
    );

    // power-state decode
    wire sys_run = (power_q == PWR_ACTIVE) || (power_q == PWR_SLEEP);
    wire watch_out_ok = sys_run || (power_q == PWR_SUBACTIVE);
    wire tb_run = (power_q != PWR_STANDBY);

    // mode decode
    wire time_base = timer_mode_select_q[TIME_BASE_BIT];
    wire hold_clear = timer_mode_select_q[TIME_BASE_BIT] &
                      timer_mode_select_q[CLEAR_SEL_BIT];
    wire [2:0] tap_sel = timer_mode_select_q[2:0];
    wire [1:0] period_sel = timer_mode_select_q[1:0];
    wire [2:0] out_sel = timer_mode_select_q[OUT_SEL_MSB:OUT_SEL_MSB-2];

    // tick selection from the two prescalers
    wire [SYS_PRE_W-1:0] sys_mask = SYS_TAP_MASK[tap_sel];
    wire [WATCH_PRE_W-1:0] watch_mask = WATCH_TAP_MASK[period_sel];
    wire sys_tap = (system_prescaler_q & sys_mask) == sys_mask;
    wire watch_tap = watch_ev.rise && ((watch_prescaler_q & watch_mask) == watch_mask);
    wire interval_tick = sys_run && !time_base && sys_tap;
    wire tb_tick = tb_run && time_base && !hold_clear && watch_tap;
    wire cnt_tick = interval_tick || tb_tick;
    wire overflow = cnt_tick && (timer_count_value_q == COUNT_FULL);

    // counter next value; wrap comes from 8-bit overflow of the add
    assign count_d = hold_clear ? COUNT_RESET :
                     cnt_tick ? timer_count_value_q + 8'h01 :
                     timer_count_value_q;

    // system prescaler stops outside active and sleep to save power
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            system_prescaler_q <= '0;
        end else if (sys_run) begin
            system_prescaler_q <= system_prescaler_q + 13'h0001;
        end
    end

    // watch prescaler steps on each synchronised rising watch edge unless clear select holds it at zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            watch_prescaler_q <= '0;
        end else if (hold_clear) begin
            watch_prescaler_q <= '0;
        end else if (watch_ev.rise) begin
            watch_prescaler_q <= watch_prescaler_q + 7'h01;
        end
    end

    // counter register; no bus path writes it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_count_value_q <= COUNT_RESET;
        end else begin
            timer_count_value_q <= count_d;
        end
    end

    // divided clock output selection
    wire sys_bit = system_prescaler_q[CLKOUT_BIT[out_sel[1:0]]];
    wire watch_bit = watch_prescaler_q[CLKOUT_BIT[out_sel[1:0]]];
    wire out_avail = out_sel[2] ? watch_out_ok : sys_run;
    wire out_level = out_sel[2] ? watch_bit : sys_bit;
    wire clkout_d = clkout_enable_q && out_avail && out_level;

    // output and interrupt flops; pin rests low when disabled
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkout_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            clkout_q <= clkout_d;
            irq_q <= overflow_request_flag_q && overflow_irq_enable_q;
        end
    end

    // write decode, performed once address and data are both held
    wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
    wire wr_en = wr_fire && wlane_q;
    wire wr_mode = (aw_idx_q == IDX_MODE);
    wire wr_count = (aw_idx_q == IDX_COUNT);
    wire wr_stat = (aw_idx_q == IDX_IRQ_STAT);
    wire wr_mask = (aw_idx_q == IDX_IRQ_MASK);
    wire wr_port = (aw_idx_q == IDX_PORT_MODE);
    wire wr_power = (aw_idx_q == IDX_POWER);
    wire wr_hit = wr_mode || wr_count || wr_stat || wr_mask || wr_port || wr_power;
    wire power_legal = (wbyte_q[2:0] <= 3'(PWR_STANDBY));

    // read decode
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [15:0] ar_idx = s_axi_araddr[17:2];
    wire rd_mode = (ar_idx == IDX_MODE);
    wire rd_count = (ar_idx == IDX_COUNT);
    wire rd_stat = (ar_idx == IDX_IRQ_STAT);
    wire rd_mask = (ar_idx == IDX_IRQ_MASK);
    wire rd_port = (ar_idx == IDX_PORT_MODE);
    wire rd_power = (ar_idx == IDX_POWER);
    wire rd_hit = rd_mode || rd_count || rd_stat || rd_mask || rd_port || rd_power;
    wire [7:0] mode_view = timer_mode_select_q | 8'h10;
    wire [7:0] rd_byte = rd_mode ? mode_view :
                         rd_count ? timer_count_value_q :
                         rd_stat ? {7'h00, overflow_request_flag_q} :
                         rd_mask ? {7'h00, overflow_irq_enable_q} :
                         rd_port ? {7'h00, clkout_enable_q} :
                         rd_power ? {5'h00, power_q} : 8'h00;
    wire stat_clear = ar_fire && rd_stat;

    // software-written control registers; bit 4 of mode never stored low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_mode_select_q <= MODE_RESET;
            overflow_irq_enable_q <= 1'b0;
            clkout_enable_q <= 1'b0;
            power_q <= PWR_ACTIVE;
        end else if (wr_en) begin
            if (wr_mode) begin
                timer_mode_select_q <= {wbyte_q[7:5], 1'b1, wbyte_q[3:0]};
            end
            if (wr_mask) begin
                overflow_irq_enable_q <= wbyte_q[0];
            end
            if (wr_port) begin
                clkout_enable_q <= wbyte_q[0];
            end
            if (wr_power && power_legal) begin
                power_q <= itbt_power_type'(wbyte_q[2:0]);
            end
        end
    end

    // sticky flag: read clears, a same-cycle overflow wins
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_request_flag_q <= 1'b0;
        end else begin
            overflow_request_flag_q <= (overflow_request_flag_q && !stat_clear)
                                       || overflow;
        end
    end

    // write address and data channels, accepted in either order
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            awready_q <= 1'b0;
            aw_idx_q <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
            aw_idx_q <= s_axi_awaddr[17:2];
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end else if (!aw_have_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_have_q <= 1'b0;
            wready_q <= 1'b0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end else if (!w_have_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    // write response; unmapped index answers slverr
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready && bvalid_q) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel, data captured at the address handshake
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rbyte_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rbyte_q <= rd_byte;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready && rvalid_q) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign divided_clock_out = clkout_q;
    assign irq = irq_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = {24'h00_0000, rbyte_q};

    // checks on the design's own outputs and internal state
    property p_mode_bit4;
        @(posedge core_clk) disable iff (!reset_n)
        (ar_fire && rd_mode) |=> (s_axi_rvalid && s_axi_rdata[MODE_RSVD_BIT]);
    endproperty
    a_mode_bit4: assert property (p_mode_bit4) else $error("mode bit 4 read low");

    property p_hold_clear;
        @(posedge core_clk) disable iff (!reset_n)
        hold_clear |=> (timer_count_value_q == 8'h00) && (watch_prescaler_q == 7'h00);
    endproperty
    a_hold_clear: assert property (p_hold_clear) else $error("clear select not clearing");

    property p_ovf_flag;
        @(posedge core_clk) disable iff (!reset_n)
        (cnt_tick && timer_count_value_q == 8'hff) |=> overflow_request_flag_q;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_wrap;
        @(posedge core_clk) disable iff (!reset_n)
        (cnt_tick && !hold_clear && timer_count_value_q == 8'hff) |=> timer_count_value_q == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_irq_gate;
        @(posedge core_clk) disable iff (!reset_n)
        irq |-> $past(overflow_request_flag_q && overflow_irq_enable_q);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enabled flag");

    property p_out_enable;
        @(posedge core_clk) disable iff (!reset_n)
        divided_clock_out |-> $past(clkout_enable_q);
    endproperty
    a_out_enable: assert property (p_out_enable) else $error("clock out while disabled");

    property p_sys_out_gate;
        @(posedge core_clk) disable iff (!reset_n)
        (!sys_run && !out_sel[2]) |=> !divided_clock_out;
    endproperty
    a_sys_out_gate: assert property (p_sys_out_gate) else $error("system clock out when halted");

    property p_count_cause;
        @(posedge core_clk) disable iff (!reset_n)
        (timer_count_value_q != $past(timer_count_value_q)) |-> $past(cnt_tick || hold_clear);
    endproperty
    a_count_cause: assert property (p_count_cause) else $error("counter moved without tick");

    property p_interval_halt;
        @(posedge core_clk) disable iff (!reset_n)
        (!sys_run && !time_base) |=> $stable(timer_count_value_q);
    endproperty
    a_interval_halt: assert property (p_interval_halt) else $error("interval counter ran halted");

    property p_read_answer;
        @(posedge core_clk) disable iff (!reset_n)
        ar_fire |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer missing");

    c_overflow: cover property (@(posedge core_clk) disable iff (!reset_n) overflow);
    c_irq: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(irq));
    c_tb_tick: cover property (@(posedge core_clk) disable iff (!reset_n) tb_tick);
    c_clkout: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(divided_clock_out));

endmodule : itbt_timer

// ==== hdl/itbt_pkg.sv ====
// constants, register map and types of the interval and time-base timer
// assumes a 250 MHz core clock and an asynchronous 32.768 kHz watch clock pin
package itbt_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_MODE = 16'hffb0;
    localparam logic [15:0] IDX_COUNT = 16'hffb1;
    localparam logic [15:0] IDX_IRQ_STAT = 16'hffb8;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hffb9;
    localparam logic [15:0] IDX_PORT_MODE = 16'hffba;
    localparam logic [15:0] IDX_POWER = 16'hffbb;

    // values after reset, counter full value and reserved mode bit
    localparam logic [7:0] MODE_RESET = 8'h10;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_FULL = 8'hff;
    localparam int MODE_RSVD_BIT = 4;

    // mode register field positions
    localparam int OUT_SEL_MSB = 7;
    localparam int TIME_BASE_BIT = 3;
    localparam int CLEAR_SEL_BIT = 2;

    // prescaler widths
    localparam int SYS_PRE_W = 13;
    localparam int WATCH_PRE_W = 7;

    // system tap masks, indexed by the low three mode bits: /8192 .. /8
    localparam logic [SYS_PRE_W-1:0] SYS_TAP_MASK [8] = '{
        13'h1fff, 13'h0fff, 13'h07ff, 13'h01ff,
        13'h00ff, 13'h007f, 13'h001f, 13'h0007};

    // watch tap masks for 1 s, 0.5 s, 0.25 s, 0.03125 s overflow periods
    localparam logic [WATCH_PRE_W-1:0] WATCH_TAP_MASK [4] = '{7'h7f, 7'h3f, 7'h1f, 7'h03};

    // prescaler bit giving a square wave of /32, /16, /8, /4
    localparam logic [2:0] CLKOUT_BIT [4] = '{3'h4, 3'h3, 3'h2, 3'h1};

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PWR_ACTIVE,
        PWR_SLEEP,
        PWR_WATCH,
        PWR_SUBACTIVE,
        PWR_SUBSLEEP,
        PWR_STANDBY
    } itbt_power_type;

endpackage : itbt_pkg

// ==== hdl/itbt_edge_if.sv ====
// carrier between the watch-pin synchroniser and the timer core
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface itbt_edge_if;
    logic level;
    logic rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface : itbt_edge_if

// ==== hdl/itbt_sync_edge.sv ====
// two-stage synchroniser with rising-edge pulse for an asynchronous pin
// assumes the pin toggles far slower than core_clk
`timescale 1ns/1ps
module itbt_sync_edge (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic async_in,
    itbt_edge_if.src ev
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // meta_q feeds only sync_q; edge seen one stage later
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // tick lands on a core_clk edge, so up to one period of jitter
    assign ev.level = sync_q;
    assign ev.rise = sync_q & ~last_q;

endmodule : itbt_sync_edge

// ==== verification/itbt_testbench.sv ====
// self-checking bench for the interval and time-base timer
// assumes itbt_pkg and itbt_timer are compiled first; the bench drives every port
`timescale 1ns/1ps
module testbench
    import itbt_pkg::*;
;
    typedef struct packed {
        logic wr;
        logic [15:0] idx;
        logic [7:0] d;
        logic [7:0] e;
        logic [1:0] r;
    } itbt_row_type;

    // watch pin is sped up to 16 core cycles a period so the run stays short
    localparam int WP = 16;
    localparam int TB_DIV [4] = '{128, 64, 32, 4};
    localparam itbt_row_type ROWS [16] = '{
        '{1'b0, IDX_MODE, 8'h00, 8'h10, RESP_OKAY},
        '{1'b0, IDX_COUNT, 8'h00, 8'h00, RESP_OKAY},
        '{1'b0, IDX_IRQ_STAT, 8'h00, 8'h00, RESP_OKAY},
        '{1'b0, IDX_IRQ_MASK, 8'h00, 8'h00, RESP_OKAY},
        '{1'b0, IDX_PORT_MODE, 8'h00, 8'h00, RESP_OKAY},
        '{1'b0, IDX_POWER, 8'h00, 8'h00, RESP_OKAY},
        '{1'b1, IDX_MODE, 8'h0c, 8'h00, RESP_OKAY},
        '{1'b0, IDX_MODE, 8'h00, 8'h1c, RESP_OKAY},
        '{1'b1, IDX_COUNT, 8'h55, 8'h00, RESP_OKAY},
        '{1'b0, IDX_COUNT, 8'h00, 8'h00, RESP_OKAY},
        '{1'b1, IDX_MODE, 8'hef, 8'h00, RESP_OKAY},
        '{1'b0, IDX_MODE, 8'h00, 8'hff, RESP_OKAY},
        '{1'b1, IDX_POWER, 8'h06, 8'h00, RESP_OKAY},
        '{1'b0, IDX_POWER, 8'h00, 8'h00, RESP_OKAY},
        '{1'b0, 16'hffbf, 8'h00, 8'h00, RESP_SLVERR},
        '{1'b1, 16'hffbf, 8'h55, 8'h00, RESP_SLVERR}};

    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic watch_clk_pin = 1'b0;
    logic divided_clock_out;
    logic irq;
    logic [17:0] s_axi_awaddr = 18'h0_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [17:0] s_axi_araddr = 18'h0_0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    int cyc = 0;
    int bad_count = 0;
    int checked = 0;

    itbt_timer DUT (
        .core_clk(core_clk), .reset_n(reset_n), .watch_clk_pin(watch_clk_pin),
        .divided_clock_out(divided_clock_out), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // core clock, cycle count, watch pin toggled on the core edge each half period
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    always @(posedge core_clk) begin
        if (cyc % (WP / 2) == 0)
            watch_clk_pin <= ~watch_clk_pin;
    end

    task automatic end_sim;
        $display("TB: checked %0d, bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_in(input logic [31:0] got, input int lo, input int hi, input string msg);
        checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %0d want %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask : chk_in

    // address and data offered together, each dropped once taken
    // no cycle limit here: only the watchdog ends a stuck wait
    task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic w(input logic [15:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(idx, d, r);
    endtask : w

    task automatic rd(input logic [15:0] idx, output logic [31:0] v);
        logic [1:0] r;
        axi_rd(idx, v, r);
    endtask : rd

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
        t = cyc;
    endtask : wait_irq

    task automatic wait_clk(input logic v);
        int n;
        n = 0;
        while (divided_clock_out !== v && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_clk

    // one full period of the pin, rise to rise, in core cycles
    task automatic period(output int p);
        int t0;
        wait_clk(1'b0);
        wait_clk(1'b1);
        t0 = cyc;
        wait_clk(1'b0);
        wait_clk(1'b1);
        p = cyc - t0;
    endtask : period

    task automatic quiet(output int h);
        h = 0;
        repeat (4) @(posedge core_clk);
        repeat (600) begin
            @(posedge core_clk);
            if (divided_clock_out !== 1'b0) h++;
        end
    endtask : quiet

    initial begin
        #250_000;
        bad_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        end_sim();
    end

    initial begin
        logic [31:0] v;
        logic [1:0] r;
        int a, t0, t1, p, h;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        // register table: reset values, reserved bit, read-only count, unmapped
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) begin
                axi_wr(ROWS[i].idx, ROWS[i].d, r);
                chk(r, ROWS[i].r, "write response");
            end else begin
                axi_rd(ROWS[i].idx, v, r);
                chk(v, {24'h00_0000, ROWS[i].e}, "read data");
                chk(r, ROWS[i].r, "read response");
            end
        end
        // overflow period at the two fastest taps; a stale flag needs two cycles to leave irq
        w(IDX_IRQ_MASK, 8'h01);
        for (int k = 0; k < 2; k++) begin
            w(IDX_MODE, 8'h07 - k[7:0]);
            rd(IDX_IRQ_STAT, v);
            repeat (2) @(posedge core_clk);
            wait_irq(t0);
            rd(IDX_IRQ_STAT, v);
            chk(v, 1, "flag set on overflow");
            rd(IDX_IRQ_STAT, v);
            chk(v, 0, "flag cleared by read");
            chk(irq, 1'b0, "irq follows flag");
            wait_irq(t1);
            chk(t1 - t0, 2048 << (2 * k), "overflow period");
        end
        // masked: fastest tap guarantees a fresh overflow inside the window, irq stays low
        w(IDX_IRQ_MASK, 8'h00);
        w(IDX_MODE, 8'h07);
        rd(IDX_IRQ_STAT, v);
        h = 0;
        repeat (2100) begin
            @(posedge core_clk);
            if (irq !== 1'b0) h++;
        end
        chk(h, 0, "masked irq");
        rd(IDX_IRQ_STAT, v);
        chk(v, 1, "flag while masked");
        // clear select holds zero for every low pair
        for (int k = 12; k < 16; k++) begin
            w(IDX_MODE, 8'h07);
            repeat (40) @(posedge core_clk);
            w(IDX_MODE, k[7:0]);
            repeat (40) @(posedge core_clk);
            rd(IDX_COUNT, v);
            chk(v, 0, "held clear");
        end
        // interval count halts in subactive and resumes in active
        w(IDX_MODE, 8'h07);
        w(IDX_POWER, 8'h03);
        rd(IDX_COUNT, v);
        a = v;
        repeat (100) @(posedge core_clk);
        rd(IDX_COUNT, v);
        chk(v, a, "interval halted");
        w(IDX_POWER, 8'h00);
        repeat (100) @(posedge core_clk);
        rd(IDX_COUNT, v);
        chk_in(v, a + 10, a + 16, "interval resumes");
        // time base periods counted in subactive, four ticks each
        w(IDX_POWER, 8'h03);
        for (int k = 0; k < 4; k++) begin
            w(IDX_MODE, 8'h0f);
            w(IDX_MODE, 8'h08 + k[7:0]);
            repeat (4 * TB_DIV[k] * WP) @(posedge core_clk);
            rd(IDX_COUNT, v);
            chk_in(v, 3, 4, "time base ticks");
        end
        w(IDX_POWER, 8'h05);
        rd(IDX_COUNT, v);
        a = v;
        repeat (200) @(posedge core_clk);
        rd(IDX_COUNT, v);
        chk(v, a, "time base halted in standby");
        w(IDX_POWER, 8'h00);
        // divided clock pin: off when disabled, then all eight codes
        w(IDX_MODE, 8'h67);
        quiet(h);
        chk(h, 0, "pin idle when disabled");
        w(IDX_PORT_MODE, 8'h01);
        for (int k = 0; k < 8; k++) begin
            w(IDX_MODE, {k[2:0], 5'h07});
            repeat (4) @(posedge core_clk);
            period(p);
            chk(p, (32 >> (k % 4)) * (k >= 4 ? WP : 1), "output period");
        end
        w(IDX_POWER, 8'h03);
        w(IDX_MODE, 8'h67);
        quiet(h);
        chk(h, 0, "system output off in subactive");
        w(IDX_MODE, 8'he7);
        repeat (4) @(posedge core_clk);
        period(p);
        chk(p, 4 * WP, "watch output in subactive");
        // second reset in mid-run
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(divided_clock_out, 1'b0, "pin low in reset");
        reset_n <= 1'b1;
        rd(IDX_MODE, v);
        chk(v, 32'h0000_0010, "mode after reset");
        rd(IDX_PORT_MODE, v);
        chk(v, 32'h0000_0000, "port after reset");
        end_sim();
    end
endmodule : testbench
